// File: shared/ssi_link_map.svh
// Timing figures and defaults for the synchronous serial position link.
`ifndef SSI_LINK_MAP_SVH
`define SSI_LINK_MAP_SVH

// ************************************************************
// System clock
// ************************************************************
`define SSI_CLK_PERIOD_NS        25

// ************************************************************
// Link timing
// ************************************************************
// Typical recovery interval after the last clock edge.
`define SSI_RECOVERY_INTERVAL_NS 12000
// Least inter-read pause between two clock sequences.
`define SSI_INTER_READ_PAUSE_NS  20000
// Least time rounds up to whole cycles.
`define SSI_RECOVERY_CYCLES \
   ((`SSI_RECOVERY_INTERVAL_NS + `SSI_CLK_PERIOD_NS - 1) / `SSI_CLK_PERIOD_NS)
// The pause must be strictly longer than the figure, hence one cycle more.
`define SSI_INTER_READ_PAUSE_CYCLES \
   ((`SSI_INTER_READ_PAUSE_NS / `SSI_CLK_PERIOD_NS) + 1)

// ************************************************************
// Defaults
// ************************************************************
`define SSI_WORD_BITS_DEFAULT    17
// Half period of the generated link clock in system clocks: 2 MHz.
`define SSI_HALF_DIV_DEFAULT     10
// Fastest link clock allowed is 4 MHz, i.e. a half period of 5 cycles.
`define SSI_HALF_DIV_MIN         5
// Slowest link clock allowed is 100 kHz, i.e. a half period of 200 cycles.
`define SSI_HALF_DIV_MAX         200

`endif

// File: shared/ssi_link_pkg.sv
// Types shared by both ends of the synchronous serial position link.
package ssi_link_pkg;

   typedef enum logic {
      code_binary,
      code_gray
   } code_e;

   typedef enum logic {
      slave_ready,
      slave_busy
   } slave_state_e;

   typedef enum logic [1:0] {
      master_idle,
      master_low,
      master_high,
      master_pause
   } master_state_e;

endpackage

// File: shared/ssi_link_if.sv
// Two-wire link between the position controller and the encoder slave.
interface ssi_link_if;
   logic sclk;
   logic sdata;

   modport master (
      output sclk,
      input  sdata
   );

   modport device (
      input  sclk,
      output sdata
   );
endinterface

// File: verilog/ssi_encoder_slave.sv
// Encoder end of the synchronous serial position link.
// Notes on behaviour
// - First falling clock edge captures the position.
// - First following rising edge drives the MSB.
// - Each later rising edge shifts next bit.
// - Extra clocks beyond the word and any enabled control bit output zero.
// - MSB first, padding zeros after the word and any enabled control bit.
// - After recovery interval, data line returns high.
// - Recovery may start right after last bit.
// - Master clocks at least word length bits.
// - Word length is a build parameter.
// - Binary or Gray code, fixed per build.
// - Master clock between 100 kHz and 4 MHz.
// - Master slows clock for longer cables.
// - Master pauses over 20 us between reads.
// - Count rises clockwise, direction not configurable.
// - Single slave on a point-to-point link.
// - Optional control bit follows the process data.
`include "ssi_link_map.svh"

module ssi_encoder_slave #(
   parameter int                  WORD_BITS   = `SSI_WORD_BITS_DEFAULT,
   parameter ssi_link_pkg::code_e CODE        = ssi_link_pkg::code_binary,
   parameter bit                  CTRL_BIT_EN = 1'b0
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic [WORD_BITS-1:0] position,
   input  wire logic                 ctrl_bit,
   output logic                      ready,
   ssi_link_if.device                link
);
   import ssi_link_pkg::*;

   // ************************************************************
   // Build checks
   // ************************************************************
   localparam int RECOVERY_CYCLES = `SSI_RECOVERY_CYCLES;
   localparam int TIMER_W         = $clog2(RECOVERY_CYCLES + 1);

   if (!(WORD_BITS == 17 || WORD_BITS == 21 || WORD_BITS == 22 ||
         WORD_BITS == 33 || WORD_BITS == 37 || WORD_BITS == 38)) begin : g_bad_width
      $error("Word length must be 17, 21 or 22, optionally plus 16 turn bits.");
   end

   // ************************************************************
   // Encoding
   // ************************************************************
   function automatic logic [WORD_BITS-1:0] encode(input logic [WORD_BITS-1:0] bin);
      logic [WORD_BITS-1:0] res;
      res = bin;
      if (CODE == code_gray) begin
         res = bin ^ (bin >> 1);
      end
      return res;
   endfunction

   // ************************************************************
   // Clock pin synchroniser (system clock side)
   // ************************************************************
   logic sclk_s1;
   logic sclk_s2;
   logic sclk_s3;
   logic sclk_f;
   logic agree;
   logic fall_ev;
   logic rise_ev;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_s1 <= 1'b1;
         sclk_s2 <= 1'b1;
         sclk_s3 <= 1'b1;
      end else begin
         sclk_s1 <= link.sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
      end
   end

   // A level change is accepted only once the last two stages agree.
   assign agree   = (sclk_s2 == sclk_s3);
   assign fall_ev = agree && !sclk_s3 && sclk_f;
   assign rise_ev = agree && sclk_s3 && !sclk_f;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_f <= 1'b1;
      end else if (agree) begin
         sclk_f <= sclk_s3;
      end
   end

   // ************************************************************
   // Read cycle state and recovery timer
   // ************************************************************
   slave_state_e           state;
   logic [TIMER_W-1:0]     timer;
   logic                   timer_done;

   assign timer_done = (timer == TIMER_W'(RECOVERY_CYCLES));

   // recovery from last edge
   // The timer restarts on every clock edge and only runs while the clock
   // rests high, so it expires after the final edge with no extra clocks.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timer <= '0;
      end else if (state == slave_ready || fall_ev || rise_ev || !sclk_f) begin
         timer <= '0;
      end else if (!timer_done) begin
         timer <= timer + TIMER_W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= slave_ready;
      end else begin
         case (state)
            slave_ready: begin
               if (fall_ev) begin
                  state <= slave_busy;
               end
            end
            slave_busy: begin
               if (timer_done && sclk_f) begin
                  state <= slave_ready;
               end
            end
            default: begin
               state <= slave_ready;
            end
         endcase
      end
   end

   assign ready = (state == slave_ready);

   // ************************************************************
   // Position capture
   // ************************************************************
   // The snapshot is written a few system clocks after the falling edge and
   // is read at the next rising link edge. At the fastest allowed link rate
   // the half period is five system clocks, so the word is settled one system
   // clock before the link side reads it; the toggle tells the link side that a
   // fresh word is waiting. Both are static while the link side samples.
   logic [WORD_BITS:0] snapshot;
   logic               start_tgl;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         snapshot  <= '0;
         start_tgl <= 1'b0;
      end else if (state == slave_ready && fall_ev) begin
         snapshot  <= {encode(position), CTRL_BIT_EN ? ctrl_bit : 1'b0};
         start_tgl <= ~start_tgl;
      end
   end

   // ************************************************************
   // Link side shifter (link clock domain)
   // ************************************************************
   logic [WORD_BITS:0] shifter;
   logic               seen_tgl;

   always_ff @(posedge link.sclk or posedge rst) begin
      if (rst) begin
         seen_tgl <= 1'b0;
      end else begin
         seen_tgl <= start_tgl;
      end
   end

   always_ff @(posedge link.sclk or posedge rst) begin
      if (rst) begin
         shifter <= '0;
      end else if (start_tgl != seen_tgl) begin
         shifter <= snapshot;
      end else begin
         shifter <= {shifter[WORD_BITS-1:0], 1'b0};
      end
   end

   // ************************************************************
   // Data line
   // ************************************************************
   // idle high, shifted data otherwise
   // After n+1 rising edges the shifter holds zero with the control bit off (n+2 with it on), so the line stays low
   // through the recovery interval. The line joins a system clock flop and
   // a link clock flop; the master samples it only well after either moves.
   assign link.sdata = (state == slave_ready) ? 1'b1 : shifter[WORD_BITS];

   // one slave per link
   // The interface carries exactly one device end; no chaining input exists.

endmodule

// File: verilog/ssi_position_master.sv
// Controller end of the synchronous serial position link.
`include "ssi_link_map.svh"

module ssi_position_master #(
   parameter int WORD_BITS = `SSI_WORD_BITS_DEFAULT,
   parameter int HALF_DIV  = `SSI_HALF_DIV_DEFAULT,
   parameter int PAUSE_CYC = `SSI_INTER_READ_PAUSE_CYCLES
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 start,
   output logic                      busy,
   output logic                      word_valid,
   output logic [WORD_BITS-1:0]      word,
   ssi_link_if.master                link
);
   import ssi_link_pkg::*;

   // ************************************************************
   // Build checks
   // ************************************************************
   localparam int DIV_W   = $clog2(HALF_DIV + 1);
   localparam int PAUSE_W = $clog2(PAUSE_CYC + 1);
   localparam int CNT_W   = $clog2(WORD_BITS + 2);

   if (HALF_DIV < `SSI_HALF_DIV_MIN || HALF_DIV > `SSI_HALF_DIV_MAX) begin : g_bad_div
      $error("Link clock half period out of the 100 kHz to 4 MHz range.");
   end
   if (WORD_BITS < 2 || PAUSE_CYC < 1) begin : g_bad_word
      $error("Word length or pause length not supported.");
   end

   // ************************************************************
   // Data pin synchroniser
   // ************************************************************
   logic d_s1;
   logic d_s2;
   logic d_s3;
   logic data_f;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         d_s1 <= 1'b1;
         d_s2 <= 1'b1;
         d_s3 <= 1'b1;
      end else begin
         d_s1 <= link.sdata;
         d_s2 <= d_s1;
         d_s3 <= d_s2;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_f <= 1'b1;
      end else if (d_s2 == d_s3) begin
         data_f <= d_s3;
      end
   end

   // ************************************************************
   // Clock generator and sequencer
   // ************************************************************
   master_state_e        state;
   logic [DIV_W-1:0]     div;
   logic [PAUSE_W-1:0]   pause;
   logic [CNT_W-1:0]     rises;
   logic [WORD_BITS-1:0] shift_in;
   logic                 half_done;
   logic                 sclk;

   assign half_done = (div == DIV_W'(HALF_DIV - 1));
   assign busy      = (state != master_idle);
   assign link.sclk = sclk;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state      <= master_idle;
         sclk       <= 1'b1;
         div        <= '0;
         pause      <= '0;
         rises      <= '0;
         shift_in   <= '0;
         word       <= '0;
         word_valid <= 1'b0;
      end else begin
         word_valid <= 1'b0;
         case (state)
            master_idle: begin
               if (start && data_f) begin
                  sclk  <= 1'b0;
                  div   <= '0;
                  rises <= '0;
                  state <= master_low;
               end
            end
            master_low: begin
               div <= div + DIV_W'(1);
               if (half_done) begin
                  sclk  <= 1'b1;
                  div   <= '0;
                  rises <= rises + CNT_W'(1);
                  if (rises != '0) begin
                     shift_in <= {shift_in[WORD_BITS-2:0], data_f};
                  end
                  if (rises == CNT_W'(WORD_BITS)) begin
                     word       <= {shift_in[WORD_BITS-2:0], data_f};
                     word_valid <= 1'b1;
                     pause      <= '0;
                     state      <= master_pause;
                  end else begin
                     state <= master_high;
                  end
               end
            end
            master_high: begin
               div <= div + DIV_W'(1);
               if (half_done) begin
                  sclk  <= 1'b0;
                  div   <= '0;
                  state <= master_low;
               end
            end
            master_pause: begin
               if (pause == PAUSE_W'(PAUSE_CYC - 1)) begin
                  state <= master_idle;
               end else begin
                  pause <= pause + PAUSE_W'(1);
               end
            end
            default: begin
               state <= master_idle;
            end
         endcase
      end
   end

endmodule

// File: verification/ssi_link_props.sv
// Concurrent checks on the primary position link between the two ends.
module ssi_link_props #(
   parameter int WORD_BITS = 17,
   parameter int PAUSE_CYC = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic ready,
   input wire logic busy,
   input wire logic word_valid
);
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************
   // Helper counters
   // ***************************************
   // Both counters saturate or clear, so they never wrap during long idle stretches.
   logic [11:0] high_cyc;
   logic [7:0]  rise_cnt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         high_cyc <= 12'h000;
      end else if (!sclk) begin
         high_cyc <= 12'h000;
      end else if (high_cyc != 12'hFFF) begin
         high_cyc <= high_cyc + 12'h001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rise_cnt <= 8'h00;
      end else if (!busy) begin
         rise_cnt <= 8'h00;
      end else if ($rose(sclk)) begin
         rise_cnt <= rise_cnt + 8'h01;
      end
   end

   // ***************************************
   // Properties
   // ***************************************
   sequence s_low_phase;
      !sclk [*5];
   endsequence
   sequence s_capture;
      ##[1:6] !ready;
   endsequence

   property p_idle_clk;    !busy |-> sclk; endproperty
   property p_ready_data;  ready |-> sdata; endproperty
   property p_capture;     $fell(sclk) && ready |-> s_capture; endproperty
   property p_half_min;    $fell(sclk) |-> s_low_phase; endproperty
   property p_half_max;    $fell(sclk) |-> ##[1:200] sclk; endproperty
   // The counter takes the last rise one cycle after the word is handed over.
   property p_word_count;  word_valid |-> ##1 rise_cnt == WORD_BITS + 1; endproperty
   property p_data_edge;   $changed(sdata) |-> sclk || $fell(ready); endproperty
   property p_hold_high;   busy && rise_cnt == WORD_BITS + 1 |-> sclk; endproperty
   property p_fill_zero;
      !ready && rise_cnt == WORD_BITS + 1 && high_cyc > 12'h008 |-> !sdata;
   endproperty
   property p_recovery_min; $rose(ready) |-> high_cyc >= 12'h1E0; endproperty
   property p_recovery_max; high_cyc >= 12'h1F4 |-> ready; endproperty
   property p_pause;       $fell(sclk) && ready |-> high_cyc > PAUSE_CYC; endproperty

   a_idle_clk: assert property (p_idle_clk)
      else $error("clock not high while controller idle");
   a_ready_data: assert property (p_ready_data)
      else $error("data line low while encoder ready");
   a_capture: assert property (p_capture)
      else $error("first falling clock did not start a read");
   a_half_min: assert property (p_half_min)
      else $error("clock low phase too short");
   a_half_max: assert property (p_half_max)
      else $error("clock low phase too long");
   a_word_count: assert property (p_word_count)
      else $error("word delivered after wrong count of rising edges");
   a_data_edge: assert property (p_data_edge)
      else $error("data line moved while clock low outside capture");
   a_hold_high: assert property (p_hold_high)
      else $error("clock left high level after the last edge");
   a_fill_zero: assert property (p_fill_zero)
      else $error("extra clock did not give a zero");
   a_recovery_min: assert property (p_recovery_min)
      else $error("encoder ready before recovery interval");
   a_recovery_max: assert property (p_recovery_max)
      else $error("encoder not ready after recovery interval");
   a_pause: assert property (p_pause)
      else $error("pause between reads too short");
endmodule

// File: verification/ssi_absolute_position_slave_tb.sv
// Self-checking bench for both ends of the serial position link.
`include "ssi_link_map.svh"
module ssi_absolute_position_slave_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************
   // Set-up
   // ***************************************
   localparam int W     = 17;
   localparam int PAUSE = `SSI_INTER_READ_PAUSE_CYCLES;
   localparam int LHALF = 6;
   localparam int LIMIT = 30000;

   typedef struct packed {
      logic [W-1:0] pos;
      logic [W-1:0] gray;
   } row_s;

   logic         clk;
   logic         rst;
   logic         start;
   logic         busy;
   logic         word_valid;
   logic [W-1:0] word;
   logic [W-1:0] pos_a;
   logic [W-1:0] pos_b;
   logic         ready_a;
   logic         ready_b;
   logic         sclk_b;
   logic         ctrl_bit;
   logic [W-1:0] got;
   logic [W+2:0] frame;
   int           fails = 0;
   int           n_tests = 0;
   int           cycles = 0;
   int           k;
   row_s         rows [7] = '{'{17'h00000, 17'h00000}, '{17'h1FFFF, 17'h10000},
                              '{17'h10000, 17'h18000}, '{17'h00001, 17'h00001},
                              '{17'h0AAAA, 17'h0FFFF}, '{17'h15555, 17'h1FFFF},
                              '{17'h00002, 17'h00003}};

   ssi_link_if link_a ();
   ssi_link_if link_b ();
   // The second link is clocked by the bench so that it can send any number of edges.
   assign link_b.sclk = sclk_b;

   ssi_position_master #(.WORD_BITS(W), .PAUSE_CYC(PAUSE)) ssi_position_master_inst (
      .clk(clk), .rst(rst), .start(start), .busy(busy), .word_valid(word_valid),
      .word(word), .link(link_a.master));
   ssi_encoder_slave #(.WORD_BITS(W), .CODE(ssi_link_pkg::code_binary)) ssi_encoder_slave_inst (
      .clk(clk), .rst(rst), .position(pos_a), .ctrl_bit(ctrl_bit), .ready(ready_a),
      .link(link_a.device));
   ssi_encoder_slave #(.WORD_BITS(W), .CODE(ssi_link_pkg::code_gray), .CTRL_BIT_EN(1'b1))
      ssi_encoder_slave_gray_inst (
      .clk(clk), .rst(rst), .position(pos_b), .ctrl_bit(ctrl_bit), .ready(ready_b),
      .link(link_b.device));
   ssi_link_props #(.WORD_BITS(W), .PAUSE_CYC(PAUSE)) ssi_link_props_inst (
      .clk(clk), .rst(rst), .sclk(link_a.sclk), .sdata(link_a.sdata), .ready(ready_a),
      .busy(busy), .word_valid(word_valid));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == LIMIT) begin
         fails = fails + 1;
         stop_test();
      end
   end

   // ***************************************
   // Tasks
   // ***************************************
   task automatic stop_test();
      $display("compares %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check_word(input logic [W-1:0] g, input logic [W-1:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic check_bit(input logic g, input logic e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic step();
      @(posedge clk);
      #2;
      k++;
   endtask

   // The position is changed right after capture, so a late sample would show up.
   task automatic read_a(input logic [W-1:0] pos, output logic [W-1:0] g);
      pos_a = pos;
      k = 0;
      step();
      start = 1'b1;
      // A hang here ends through the cycle ceiling, which counts a mismatch.
      while (busy !== 1'b1) step();
      start = 1'b0;
      while (ready_a !== 1'b0) step();
      pos_a = ~pos;
      while (word_valid !== 1'b1) step();
      g = word;
   endtask

   task automatic read_b(input int nrise, output logic [W+2:0] f);
      f = '0;
      k = 0;
      while (ready_b !== 1'b1) step();
      repeat (PAUSE) step();
      sclk_b = 1'b0;
      for (int i = 0; i < nrise; i++) begin
         repeat (LHALF) step();
         sclk_b = 1'b1;
         repeat (LHALF) step();
         f = {f[W+1:0], link_b.sdata};
         if (i < nrise - 1) sclk_b = 1'b0;
      end
   endtask

   task automatic check_idle();
      check_bit(link_a.sclk, 1'b1);
      check_bit(link_a.sdata, 1'b1);
      check_bit(link_b.sdata, 1'b1);
      check_bit(ready_a, 1'b1);
      check_bit(busy, 1'b0);
      check_bit(word_valid, 1'b0);
      check_word(word, '0);
   endtask

   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      rst = 1'b1;
      start = 1'b0;
      pos_a = '0;
      pos_b = '0;
      ctrl_bit = 1'b1;
      sclk_b = 1'b1;
      repeat (10) step();
      check_idle();
      repeat (10) step();
      rst = 1'b0;
      repeat (PAUSE + 40) step();
      $display("test reset done");
      foreach (rows[i]) begin
         read_a(rows[i].pos, got);
         check_word(got, rows[i].pos);
         pos_b = rows[i].pos;
         read_b(W + 3, frame);
         check_word(frame[W+2:3], rows[i].gray);
         check_bit(frame[2], 1'b1);
         check_bit(|frame[1:0], 1'b0);
      end
      $display("test rows done");
      pos_b = 17'h0AAAA;
      read_b(W, frame);
      check_word(frame[W-1:0], 17'h0FFFF);
      k = 0;
      while (ready_b !== 1'b1) step();
      check_bit(k + LHALF >= `SSI_RECOVERY_CYCLES && k + LHALF <= `SSI_RECOVERY_CYCLES + 15,
                1'b1);
      $display("test short read done");
      step();
      start = 1'b1;
      repeat (100) step();
      rst = 1'b1;
      start = 1'b0;
      repeat (3) step();
      check_idle();
      rst = 1'b0;
      repeat (PAUSE + 40) step();
      read_a(17'h1E0F1, got);
      check_word(got, 17'h1E0F1);
      $display("test reset in read done");
      stop_test();
   end
endmodule
